// [pkg/lci_pkg.sv]
package lci_pkg;
    // event kinds, one slot pair each
    localparam int NUM_KINDS = 5;
    localparam logic [2:0] KIND_TOP = 3'h0;
    localparam logic [2:0] KIND_PIPE = 3'h1;
    localparam logic [2:0] KIND_THREAD = 3'h2;
    localparam logic [2:0] KIND_GLOBAL = 3'h3;
    localparam logic [2:0] KIND_PM = 3'h4;
    localparam logic [1:0] SLOT_DEPTH = 2'h2;
    // pool sizing
    localparam int NUM_WAYS = 64;
    localparam logic [9:0] SCRATCH_KB_FULL = 10'h100;
    localparam logic [9:0] SCRATCH_KB_SMALL = 10'h080;
    localparam int RETURN_GRAN_SHIFT = 3;

    typedef enum logic [5:0] {
        ST_IDLE = 6'h01,
        ST_AGREE = 6'h02,
        ST_DRAIN = 6'h04,
        ST_ISSUE = 6'h08,
        ST_WAIT = 6'h10,
        ST_DONE = 6'h20
    } lci_state_e;

    typedef enum logic [1:0] {
        STREAM_REST = 2'h0,
        STREAM_DC = 2'h1,
        STREAM_RO = 2'h2
    } lci_stream_e;

    typedef enum logic [1:0] {
        CLIENT_INST_STATE = 2'h0,
        CLIENT_CONST = 2'h1,
        CLIENT_TEX = 2'h2,
        CLIENT_DC = 2'h3
    } lci_client_e;

    typedef struct packed {
        logic [NUM_WAYS-1:0] restWays;
        logic [NUM_WAYS-1:0] dcWays;
        logic [NUM_WAYS-1:0] roWays;
    } lci_alloc_s;

    typedef struct packed {
        logic topDone;
        logic pipeDone;
        logic dpRespond;
        logic cfgDone;
        logic pmDone;
    } lci_done_s;
endpackage

// [rtl/lci_coordinator.sv]
`timescale 1ns/1ps

// Behaviour
// - top invalidation waits for every slice
// - no transactions forwarded until all slices done
// - events serialized, two slots per kind
// - pipeline flush completes on local node only
// - flush fences super queue until invalidation done
// - coherent: no writeback, drain store queue first
// - thread flush: uncacheable, peers agree, then respond
// - global invalidation completes back to config agent
// - global targets global lines, virtual and physical
// - power flush returns completion status to power
// - stream flush uses current allocation only
// - scratch pool fixed 256 or 128 KB
// - return space allocated in 8 KB units
// - read-only pool groups instruction, constant, texture
// - each traffic kind uses only its own pool ways, or the rest ways when that pool is unprogrammed
// - physical lines skipped on configuration change flush
module lci_coordinator
    import lci_pkg::*;
#(
    parameter int NUM_SLICES = 2,
    parameter int RET_UNIT_W = 8
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic srst,
    // event requests, indexed by kind
    input wire logic [NUM_KINDS-1:0] reqValid,
    output logic [NUM_KINDS-1:0] reqReady,
    input wire logic coherentDomain,
    input wire logic cfgChange,
    input wire lci_stream_e flushStream,
    // slice and peer node coordination
    output logic sliceStart,
    output logic [2:0] sliceKind,
    input wire logic [NUM_SLICES-1:0] sliceDone,
    input wire logic localDone,
    output logic peerReq,
    input wire logic [NUM_SLICES-1:0] peerAgree,
    // bank side
    output logic storeDrainReq,
    input wire logic storeQueueEmpty,
    output logic llcWritebackEn,
    output logic selGlobalOnly,
    output logic selPhysical,
    output logic [NUM_WAYS-1:0] flushWayMask,
    // transaction path
    input wire logic txnValid,
    output logic txnForward,
    output logic sqHold,
    output logic streamUncacheable,
    // completions
    output lci_done_s done,
    // allocation
    input wire lci_alloc_s alloc,
    input wire lci_client_e clientClass,
    output logic [NUM_WAYS-1:0] clientWayMask,
    input wire logic scratchEn,
    input wire logic smallCfg,
    output logic [9:0] scratchKb,
    input wire logic [RET_UNIT_W-1:0] returnUnits,
    output logic [RET_UNIT_W+RETURN_GRAN_SHIFT-1:0] returnKb
);
    typedef struct packed {
        lci_state_e fsm;
        logic [2:0] kind;
        logic [NUM_KINDS-1:0][1:0] pending;
        logic [NUM_SLICES-1:0] doneSeen;
        logic sliceStart;
        logic [2:0] sliceKind;
        logic peerReq;
        logic storeDrainReq;
        logic llcWritebackEn;
        logic selGlobalOnly;
        logic selPhysical;
        logic sqHold;
        logic streamUncacheable;
        logic [NUM_WAYS-1:0] flushWayMask;
        logic [NUM_WAYS-1:0] clientWayMask;
        lci_done_s done;
        logic [9:0] scratchKb;
        logic [RET_UNIT_W+RETURN_GRAN_SHIFT-1:0] returnKb;
    } lci_state_s;

    lci_state_s s;
    lci_state_s next_s;

    // no history kept: the mask is read from the live allocation
    function automatic logic [NUM_WAYS-1:0] streamWays(lci_alloc_s a, lci_stream_e st);
        case (st)
            STREAM_DC: streamWays = a.dcWays;
            STREAM_RO: streamWays = a.roWays;
            default: streamWays = a.restWays;
        endcase
    endfunction

    // unprogrammed sub-pool falls back to the all-clients ways
    function automatic logic [NUM_WAYS-1:0] clientWays(lci_alloc_s a, lci_client_e c);
        if (c == CLIENT_DC) begin
            clientWays = (a.dcWays != '0) ? a.dcWays : a.restWays;
        end else begin
            clientWays = (a.roWays != '0) ? a.roWays : a.restWays;
        end
    endfunction

    logic [NUM_KINDS-1:0] accept;
    logic [NUM_KINDS-1:0] retire;
    logic anyPending;
    logic [2:0] pick;
    logic allSlicesDone;
    logic localKind;

    always_comb begin
        for (int k = 0; k < NUM_KINDS; k++) begin
            reqReady[k] = (s.pending[k] < SLOT_DEPTH);
        end
    end

    // a top invalidation in flight blocks new traffic into the cache
    assign txnForward = txnValid && !(s.fsm != ST_IDLE && s.kind == KIND_TOP);

    always_comb begin
        next_s = s;
        next_s.sliceStart = 1'b0;
        next_s.done = '0;
        anyPending = 1'b0;
        pick = 3'h0;
        allSlicesDone = &(s.doneSeen | sliceDone);
        localKind = (s.kind == KIND_PIPE) || (s.kind == KIND_THREAD);
        for (int k = 0; k < NUM_KINDS; k++) begin
            accept[k] = reqValid[k] && reqReady[k];
            retire[k] = (s.fsm == ST_DONE) && (s.kind == 3'(k));
            // accept and retire together leave the count unchanged
            next_s.pending[k] = s.pending[k] + {1'b0, accept[k]} - {1'b0, retire[k]};
        end
        for (int k = NUM_KINDS - 1; k >= 0; k--) begin
            if (s.pending[k] != 2'h0) begin
                anyPending = 1'b1;
                pick = 3'(k);
            end
        end
        case (s.fsm)
            ST_IDLE: begin
                if (anyPending) begin
                    next_s.kind = pick;
                    next_s.doneSeen = '0;
                    next_s.flushWayMask = streamWays(alloc, flushStream);
                    next_s.selGlobalOnly = (pick == KIND_GLOBAL) || (pick == KIND_PM);
                    // physical lines survive a reconfiguration flush
                    next_s.selPhysical = (pick == KIND_GLOBAL) || (pick == KIND_PM) || !cfgChange;
                    next_s.llcWritebackEn = !coherentDomain;
                    next_s.sqHold = (pick == KIND_PIPE);
                    next_s.streamUncacheable = 1'b1;
                    if (pick == KIND_THREAD) begin
                        next_s.fsm = ST_AGREE;
                    end else if (coherentDomain) begin
                        next_s.fsm = ST_DRAIN;
                    end else begin
                        next_s.fsm = ST_ISSUE;
                    end
                end
            end
            ST_AGREE: begin
                next_s.peerReq = 1'b1;
                if (&peerAgree) begin
                    // respond early, invalidation itself is deferred
                    next_s.peerReq = 1'b0;
                    next_s.done.dpRespond = 1'b1;
                    next_s.fsm = coherentDomain ? ST_DRAIN : ST_ISSUE;
                end
            end
            ST_DRAIN: begin
                next_s.storeDrainReq = 1'b1;
                if (storeQueueEmpty) begin
                    next_s.storeDrainReq = 1'b0;
                    next_s.fsm = ST_ISSUE;
                end
            end
            ST_ISSUE: begin
                next_s.sliceStart = 1'b1;
                next_s.sliceKind = s.kind;
                next_s.fsm = ST_WAIT;
            end
            ST_WAIT: begin
                next_s.doneSeen = s.doneSeen | sliceDone;
                if (localKind ? localDone : allSlicesDone) begin
                    next_s.fsm = ST_DONE;
                end
            end
            ST_DONE: begin
                next_s.done.topDone = (s.kind == KIND_TOP);
                next_s.done.pipeDone = (s.kind == KIND_PIPE);
                next_s.done.cfgDone = (s.kind == KIND_GLOBAL);
                next_s.done.pmDone = (s.kind == KIND_PM);
                next_s.sqHold = 1'b0;
                next_s.streamUncacheable = 1'b0;
                next_s.llcWritebackEn = 1'b1;
                next_s.selGlobalOnly = 1'b0;
                next_s.selPhysical = 1'b1;
                next_s.fsm = ST_IDLE;
            end
            default: begin
                next_s.fsm = ST_IDLE;
            end
        endcase
        // dc clients take dcWays, all other clients roWays, each falling back to restWays when empty
        next_s.clientWayMask = clientWays(alloc, clientClass);
        next_s.scratchKb = scratchEn ? (smallCfg ? SCRATCH_KB_SMALL : SCRATCH_KB_FULL) : 10'h000;
        next_s.returnKb = {returnUnits, {RETURN_GRAN_SHIFT{1'b0}}};
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            s <= '0;
            s.fsm <= ST_IDLE;
            s.llcWritebackEn <= 1'b1;
            s.selPhysical <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    assign sliceStart = s.sliceStart;
    assign sliceKind = s.sliceKind;
    assign peerReq = s.peerReq;
    assign storeDrainReq = s.storeDrainReq;
    assign llcWritebackEn = s.llcWritebackEn;
    assign selGlobalOnly = s.selGlobalOnly;
    assign selPhysical = s.selPhysical;
    assign flushWayMask = s.flushWayMask;
    assign sqHold = s.sqHold;
    assign streamUncacheable = s.streamUncacheable;
    assign done = s.done;
    assign clientWayMask = s.clientWayMask;
    assign scratchKb = s.scratchKb;
    assign returnKb = s.returnKb;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (srst);

    sequence s_issueKind(logic [2:0] k);
        sliceStart && sliceKind == k;
    endsequence

    sequence s_waitOpen;
        s.fsm == ST_WAIT && !allSlicesDone;
    endsequence

    property p_top_waits;
        (s_waitOpen and (s.kind == KIND_TOP)) |=> s.fsm == ST_WAIT && !done.topDone;
    endproperty
    a_top_waits: assert property (p_top_waits) else $error("top inval left before all slices");

    property p_top_gate;
        s_issueKind(KIND_TOP) |-> !txnForward [*2];
    endproperty
    a_top_gate: assert property (p_top_gate) else $error("traffic passed during top inval");

    // the fsm may pass through idle between two events, so only the count is judged
    property p_slots;
        (s.pending[KIND_TOP] == SLOT_DEPTH) |-> !reqReady[KIND_TOP] ##1 (s.pending[KIND_TOP] <= SLOT_DEPTH);
    endproperty
    a_slots: assert property (p_slots) else $error("third event accepted with full slots");

    property p_pipe_local;
        (s.fsm == ST_WAIT && s.kind == KIND_PIPE && localDone) |=> ##1 done.pipeDone;
    endproperty
    a_pipe_local: assert property (p_pipe_local) else $error("pipe flush not completed locally");

    property p_fence;
        s_issueKind(KIND_PIPE) |-> sqHold ##1 sqHold;
    endproperty
    a_fence: assert property (p_fence) else $error("super queue released during flush");

    property p_drain_first;
        (s.fsm == ST_DRAIN && !storeQueueEmpty) |=> !sliceStart && storeDrainReq && !llcWritebackEn;
    endproperty
    a_drain_first: assert property (p_drain_first) else $error("issued before store queue drained");

    property p_thread_resp;
        done.dpRespond |-> $past(peerAgree) == {NUM_SLICES{1'b1}} && streamUncacheable && !sliceStart;
    endproperty
    a_thread_resp: assert property (p_thread_resp) else $error("data port response without agreement");

    property p_cfg_done;
        done.cfgDone |-> $past(s.kind) == KIND_GLOBAL && $past(s.doneSeen) == {NUM_SLICES{1'b1}};
    endproperty
    a_cfg_done: assert property (p_cfg_done) else $error("config completion without all slices");

    property p_global_sel;
        s_issueKind(KIND_GLOBAL) |-> selGlobalOnly && selPhysical;
    endproperty
    a_global_sel: assert property (p_global_sel) else $error("global inval line selection wrong");

    property p_pm_done;
        done.pmDone |-> $past(s.kind) == KIND_PM && !done.cfgDone;
    endproperty
    a_pm_done: assert property (p_pm_done) else $error("power completion for wrong event");
endmodule

// [testbench/lci_slice_model.sv]
`timescale 1ns/1ps
module lci_slice_model
    import lci_pkg::*;
#(
    parameter int NUM_SLICES = 2
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic srst,
    // pace of every answer
    input wire logic [7:0] dly,
    // from the coordinator
    input wire logic sliceStart,
    input wire logic peerReq,
    input wire logic storeDrainReq,
    // answers
    output logic [NUM_SLICES-1:0] sliceDone,
    output logic localDone,
    output logic [NUM_SLICES-1:0] peerAgree,
    output logic storeQueueEmpty
);
    logic running;
    logic [7:0] runCnt;
    logic [7:0] agreeCnt;
    logic [7:0] drainCnt;
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            running <= 1'b0;
            runCnt <= 8'h00;
            agreeCnt <= 8'h00;
            drainCnt <= 8'h00;
        end else begin
            // a new start wins over the end of the previous run
            if (sliceStart) begin
                running <= 1'b1;
                runCnt <= 8'h00;
            end else if (running) begin
                runCnt <= runCnt + 8'h01;
                if (runCnt == dly + 8'(4 * NUM_SLICES)) begin
                    running <= 1'b0;
                end
            end
            agreeCnt <= peerReq ? agreeCnt + 8'(agreeCnt != 8'hFF) : 8'h00;
            drainCnt <= storeDrainReq ? drainCnt + 8'(drainCnt != 8'hFF) : 8'h00;
        end
    end
    // slices finish four cycles apart, so only the last one may end a wait
    always_comb begin
        for (int i = 0; i < NUM_SLICES; i++) begin
            sliceDone[i] = running && runCnt == dly + 8'(4 * i);
        end
    end
    assign localDone = running && runCnt == dly;
    assign peerAgree = (peerReq && agreeCnt >= dly) ? '1 : '0;
    // the queue is never reported empty unless a drain was asked for
    assign storeQueueEmpty = storeDrainReq && drainCnt >= dly;
endmodule

// [testbench/l3_cache_invalidation_allocation_bench.sv]
`timescale 1ns/1ps
module l3_cache_invalidation_allocation_bench;
    import lci_pkg::*;
    logic clk_sys = 1'b0;
    logic srst = 1'b1;
    logic [NUM_KINDS-1:0] reqValid = '0;
    logic [NUM_KINDS-1:0] reqReady;
    logic coherentDomain = 1'b0;
    logic cfgChange = 1'b0;
    lci_stream_e flushStream = STREAM_REST;
    logic sliceStart;
    logic [2:0] sliceKind;
    logic [1:0] sliceDone;
    logic localDone;
    logic peerReq;
    logic [1:0] peerAgree;
    logic storeDrainReq;
    logic storeQueueEmpty;
    logic llcWritebackEn;
    logic selGlobalOnly;
    logic selPhysical;
    logic [63:0] flushWayMask;
    logic txnValid = 1'b0;
    logic txnForward;
    logic sqHold;
    logic streamUncacheable;
    lci_done_s done;
    lci_alloc_s alloc = '{64'h0000_0000_0000_00FF, 64'h0000_0000_0000_FF00, 64'hFFFF_0000_0000_0000};
    lci_client_e clientClass = CLIENT_INST_STATE;
    logic [63:0] clientWayMask;
    logic scratchEn = 1'b0;
    logic smallCfg = 1'b0;
    logic [9:0] scratchKb;
    logic [7:0] returnUnits = 8'h00;
    logic [10:0] returnKb;
    logic [7:0] dly = 8'h06;
    int n_fail = 0;
    int total_checks = 0;
    logic gotDone, started, sawDrain, sawWbLow, sawHold, sawUnc, sawBlock, sawPeer;
    logic startGlob, startPhys;
    logic [2:0] startKind;
    logic [63:0] startMask;
    logic [1:0] seenSlice;

    lci_coordinator lci_coordinator_i (.clk_sys(clk_sys), .srst(srst), .reqValid(reqValid),
        .reqReady(reqReady), .coherentDomain(coherentDomain), .cfgChange(cfgChange),
        .flushStream(flushStream), .sliceStart(sliceStart), .sliceKind(sliceKind),
        .sliceDone(sliceDone),
        .localDone(localDone), .peerReq(peerReq), .peerAgree(peerAgree),
        .storeDrainReq(storeDrainReq), .storeQueueEmpty(storeQueueEmpty),
        .llcWritebackEn(llcWritebackEn), .selGlobalOnly(selGlobalOnly), .selPhysical(selPhysical),
        .flushWayMask(flushWayMask), .txnValid(txnValid), .txnForward(txnForward),
        .sqHold(sqHold), .streamUncacheable(streamUncacheable), .done(done), .alloc(alloc),
        .clientClass(clientClass), .clientWayMask(clientWayMask), .scratchEn(scratchEn),
        .smallCfg(smallCfg), .scratchKb(scratchKb), .returnUnits(returnUnits),
        .returnKb(returnKb));
    lci_slice_model lci_slice_model_i (.clk_sys(clk_sys), .srst(srst), .dly(dly),
        .sliceStart(sliceStart), .peerReq(peerReq), .storeDrainReq(storeDrainReq),
        .sliceDone(sliceDone), .localDone(localDone), .peerAgree(peerAgree),
        .storeQueueEmpty(storeQueueEmpty));

    always #50 clk_sys = ~clk_sys;

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wrap_up;
        if (n_fail == 0 && total_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    // issue one event of kind k and watch the outputs until its completion pulse
    task automatic run_ev(input int k);
        logic ok;
        logic [4:0] dv;
        int n;
        {gotDone, started, sawDrain, sawWbLow, sawHold, sawUnc, sawBlock, sawPeer} = '0;
        seenSlice = '0;
        ok = 1'b0;
        n = 0;
        @(posedge clk_sys);
        reqValid[k] <= 1'b1;
        while (!ok) begin
            @(negedge clk_sys);
            ok = reqReady[k];
            @(posedge clk_sys);
        end
        reqValid[k] <= 1'b0;
        while (!gotDone && n < 400) begin
            @(negedge clk_sys);
            n++;
            dv = done;
            seenSlice |= sliceDone;
            if (storeDrainReq === 1'b1 && !started) sawDrain = 1'b1;
            if (llcWritebackEn === 1'b0) sawWbLow = 1'b1;
            if (sqHold === 1'b1) sawHold = 1'b1;
            if (streamUncacheable === 1'b1) sawUnc = 1'b1;
            if (peerReq === 1'b1) sawPeer = 1'b1;
            if (txnValid && txnForward === 1'b0) sawBlock = 1'b1;
            if (sliceStart === 1'b1) begin
                started = 1'b1;
                startGlob = selGlobalOnly;
                startPhys = selPhysical;
                startMask = flushWayMask;
                startKind = sliceKind;
            end
            if (dv[4-k] === 1'b1) gotDone = 1'b1;
        end
        chk(64'(gotDone), 64'h1);
        if (started) chk(64'(startKind), 64'(k));
    endtask

    task automatic t_top;
        @(posedge clk_sys);
        txnValid <= 1'b1;
        cfgChange <= 1'b1;
        run_ev(0);
        chk(64'(&seenSlice), 64'h1);
        chk(64'(sawBlock), 64'h1);
        chk(64'(sawUnc), 64'h1);
        chk(64'({startGlob, startPhys}), 64'h0);
        repeat (3) @(negedge clk_sys);
        chk(64'(txnForward), 64'h1);
    endtask

    task automatic t_slots;
        int acc;
        int cnt;
        acc = 0;
        cnt = 0;
        dly <= 8'h1E;
        @(posedge clk_sys);
        reqValid[0] <= 1'b1;
        repeat (6) begin
            @(negedge clk_sys);
            if (reqReady[0] === 1'b1) acc++;
        end
        chk(64'(reqReady[0]), 64'h0);
        @(posedge clk_sys);
        reqValid[0] <= 1'b0;
        chk(64'(acc), 64'h2);
        repeat (300) begin
            @(negedge clk_sys);
            if (done.topDone === 1'b1) cnt++;
        end
        chk(64'(cnt), 64'h2);
        dly <= 8'h06;
    endtask

    task automatic t_pipe;
        @(posedge clk_sys);
        flushStream <= STREAM_DC;
        run_ev(1);
        chk(64'(sawHold), 64'h1);
        chk(64'(seenSlice[1]), 64'h0);
        chk(startMask, alloc.dcWays);
    endtask

    task automatic t_thread;
        run_ev(2);
        chk(64'(sawPeer), 64'h1);
        chk(64'(started), 64'h0);
        chk(64'(streamUncacheable), 64'h1);
        repeat (60) @(posedge clk_sys);
    endtask

    task automatic t_alloc;
        for (int c = 0; c < 4; c++) begin
            @(posedge clk_sys);
            clientClass <= lci_client_e'(c);
            repeat (2) @(negedge clk_sys);
            chk(clientWayMask, (c == 3) ? alloc.dcWays : alloc.roWays);
        end
        for (int s = 0; s < 3; s++) begin
            @(posedge clk_sys);
            scratchEn <= (s != 0);
            smallCfg <= (s == 2);
            // return space stays within 512 KB in 16 KB steps
            returnUnits <= 8'(64 - 2 * s);
            repeat (2) @(negedge clk_sys);
            chk(64'(scratchKb), (s == 0) ? 64'h0 : (s == 1) ? 64'h100 : 64'h80);
            chk(64'(returnKb), 64'(8 * (64 - 2 * s)));
        end
    endtask

    // reprogramming is fenced by two stalling flushes and a global invalidation
    task automatic t_realloc;
        run_ev(1);
        run_ev(1);
        run_ev(3);
        @(posedge clk_sys);
        // same masks for every bank; read-write pool either empty or large
        alloc <= '{64'h0000_0000_FFFF_0000, 64'h0000_0000_0000_0000,
            64'hFFFF_0000_0000_0000};
        clientClass <= CLIENT_DC;
        flushStream <= STREAM_DC;
        repeat (2) @(negedge clk_sys);
        chk(clientWayMask, 64'h0000_0000_FFFF_0000);
        run_ev(1);
        chk(startMask, 64'h0000_0000_0000_0000);
    endtask

    initial begin
        repeat (20000) @(posedge clk_sys);
        n_fail++;
        wrap_up();
    end

    initial begin
        repeat (12) @(posedge clk_sys);
        srst <= 1'b0;
        @(negedge clk_sys);
        chk(64'(reqReady), 64'h1F);
        chk(64'({llcWritebackEn, selPhysical}), 64'h3);
        t_top();
        t_slots();
        t_pipe();
        @(posedge clk_sys);
        coherentDomain <= 1'b1;
        run_ev(0);
        chk(64'({sawDrain, sawWbLow}), 64'h3);
        @(posedge clk_sys);
        coherentDomain <= 1'b0;
        t_thread();
        run_ev(3);
        chk(64'({startGlob, startPhys}), 64'h3);
        run_ev(4);
        t_alloc();
        t_realloc();
        wrap_up();
    end
endmodule
